// file: hdl/soc_host.sv
// Contract
// - Master clock is 37.125 MHz or 74.25 MHz.
// - Clock setting 1 is 28h or 18h; 2 and 4 per clock; 3 is 20h.
// - Hold-only write: 5 line window, 2 lines communication forbidden.
// - In slave mode both syncs driven High before soft reset.
// - No soft reset in CSI-2 mode nor in a continuous-address write.
// - Mode changes go through standby, except a few live settings.
// - Clock, width and format changes made in standby, then cancel.
// - Clear held Low at least 500 ns with chip select High.
// - Wait at least 20 us after clear release before communicating.
// - Master clock stable before clear is raised.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "soc_cfg.svh"

module soc_host #(
    parameter int CLR_CYC    = `SOC_CLR_CYC,
    parameter int XCE_CYC    = `SOC_XCE_CYC,
    parameter int LINE_CYC   = `SOC_LINE_CYC,
    parameter int SCK_HALF   = `SOC_SCK_HALF
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             clear_n,
    output logic             comm_enable_n,
    output logic             serial_clk,
    output logic             serial_data,
    input  wire logic        vertical_sync_in,
    output logic             vertical_sync_out,
    output logic             vertical_sync_oe_n,
    input  wire logic        horizontal_sync_in,
    output logic             horizontal_sync_out,
    output logic             horizontal_sync_oe_n
);

    // ======================================================
    // Declarations
    soc_pkg::soc_state_t state;
    soc_pkg::soc_seq_t   seq;
    logic [31:0] config_reg;
    logic [15:0] raw_reg;
    logic        slave_mode;
    logic        hold_value;
    logic        refused;
    logic        ready;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_fire;
    logic        ctrl_hit;
    logic [3:0]  cmd;
    logic        cmd_ok;
    logic [3:0]  step;
    logic [3:0]  last_step;
    logic [15:0] timer;
    logic [23:0] shifter;
    logic [4:0]  bit_cnt;
    logic [7:0]  sck_cnt;
    logic [1:0]  hs_sync;
    logic        hs_prev;
    logic [1:0]  line_cnt;
    logic [7:0]  step_addr;
    logic [7:0]  step_data;

    // ======================================================
    // Byte-lane merge
    function automatic logic [31:0] soc_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ======================================================
    // AXI4-Lite write channel
    assign s_axi_awready = !aw_got && !s_axi_bvalid;
    assign s_axi_wready  = !w_got && !s_axi_bvalid;
    assign wr_fire       = aw_got && w_got && !s_axi_bvalid;
    assign ctrl_hit      = wr_fire && (aw_addr == `SOC_OFS_CTRL) && w_strb[0];
    assign cmd           = ctrl_hit ? w_data[3:0] : 4'h0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got  <= 1'b0;
            w_got   <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got  <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got  <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_got <= 1'b0;
                w_got  <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr[7:4] == 4'h0 && aw_addr[1:0] == 2'h0) ? 2'h0 : 2'h2;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ======================================================
    // Own registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            config_reg <= `SOC_CONFIG_RESET;
            raw_reg    <= 16'h0000;
            slave_mode <= 1'b0;
            hold_value <= 1'b0;
        end
        else if (wr_fire)
        begin
            if (aw_addr == `SOC_OFS_CONFIG)
            begin
                config_reg <= soc_merge(config_reg, w_data, w_strb) & 32'h0000_0F37;
            end
            if (aw_addr == `SOC_OFS_RAW)
            begin
                raw_reg <= 16'(soc_merge({16'h0000, raw_reg}, w_data, w_strb));
            end
            if (aw_addr == `SOC_OFS_CTRL && w_strb[1])
            begin
                slave_mode <= w_data[`SOC_CTRL_SLAVE];
                hold_value <= w_data[`SOC_CTRL_HOLDVAL];
            end
        end
    end

    // Refused flag: hardware set wins over write-one clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            refused <= 1'b0;
        end
        else if (cmd != 4'h0 && !cmd_ok)
        begin
            refused <= 1'b1;
        end
        else if (wr_fire && aw_addr == `SOC_OFS_STATUS && w_strb[0]
                 && w_data[`SOC_STAT_REFUSED])
        begin
            refused <= 1'b0;
        end
    end

    // ======================================================
    // AXI4-Lite read channel
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            unique case (s_axi_araddr)
                `SOC_OFS_CTRL:   s_axi_rdata <= {22'h0, hold_value, slave_mode, 8'h00};
                `SOC_OFS_CONFIG: s_axi_rdata <= config_reg;
                `SOC_OFS_RAW:    s_axi_rdata <= {16'h0000, raw_reg};
                `SOC_OFS_STATUS: s_axi_rdata <= {29'h0, refused, ready,
                                                 state != soc_pkg::SOC_ST_IDLE};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ======================================================
    // Command acceptance
    always_comb
    begin
        cmd_ok = 1'b0;
        if (state == soc_pkg::SOC_ST_IDLE && ready)
        begin
            unique case (cmd)
                4'h1: cmd_ok = config_reg[`SOC_CFG_FR_LO +: 2] != `SOC_FR_PROHIBITED;
                4'h2: cmd_ok = config_reg[`SOC_CFG_FMT_LO +: 4] != `SOC_FMT_CSI2;
                4'h4: cmd_ok = 1'b1;
                4'h8: cmd_ok = 1'b1;
                default: cmd_ok = 1'b0;
            endcase
        end
    end

    // ======================================================
    // Device write for each sequence step
    always_comb
    begin
        step_addr = `SOC_DEV_STANDBY;
        step_data = 8'h00;
        unique case (seq)
            soc_pkg::SOC_SEQ_SRESET:
            begin
                step_addr = `SOC_DEV_SRESET;
                step_data = 8'h01;
            end
            soc_pkg::SOC_SEQ_RAW:
            begin
                step_addr = raw_reg[7:0];
                step_data = raw_reg[15:8];
            end
            soc_pkg::SOC_SEQ_HOLD:
            begin
                step_addr = `SOC_DEV_HOLD;
                step_data = {7'h00, hold_value};
            end
            soc_pkg::SOC_SEQ_CONFIG:
            begin
                unique case (step)
                    4'h0: step_data = 8'h01;
                    4'h1:
                    begin
                        step_addr = `SOC_DEV_OUTPUT;
                        step_data = {config_reg[`SOC_CFG_FMT_LO +: 4], 3'h0,
                                     config_reg[`SOC_CFG_OUT12]};
                    end
                    4'h2:
                    begin
                        step_addr = `SOC_DEV_ADC;
                        step_data = {7'h00, config_reg[`SOC_CFG_ADC12]};
                    end
                    4'h3:
                    begin
                        step_addr = `SOC_DEV_FRAME_RATE;
                        step_data = {6'h00, config_reg[`SOC_CFG_FR_LO +: 2]};
                    end
                    4'h4:
                    begin
                        step_addr = `SOC_DEV_CLK1;
                        step_data = config_reg[`SOC_CFG_OUT12] ? `SOC_CLK1_12BIT
                                                               : `SOC_CLK1_10BIT;
                    end
                    4'h5, 4'h7:
                    begin
                        step_addr = (step == 4'h5) ? `SOC_DEV_CLK2 : `SOC_DEV_CLK4;
                        step_data = config_reg[`SOC_CFG_CLK74] ? `SOC_CLK24_74M
                                                               : `SOC_CLK24_37M;
                    end
                    4'h6:
                    begin
                        step_addr = `SOC_DEV_CLK3;
                        step_data = `SOC_CLK3_VAL;
                    end
                    default: step_data = 8'h00;
                endcase
            end
            default: step_data = 8'h00;
        endcase
    end

    // ======================================================
    // Line edge detection from device horizontal sync
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hs_sync <= 2'h3;
            hs_prev <= 1'b1;
        end
        else
        begin
            hs_sync <= {hs_sync[0], horizontal_sync_in};
            hs_prev <= hs_sync[1];
        end
    end

    // ======================================================
    // Sequencer and serial engine
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state         <= soc_pkg::SOC_ST_CLEAR;
            seq           <= soc_pkg::SOC_SEQ_RAW;
            ready         <= 1'b0;
            step          <= 4'h0;
            last_step     <= 4'h0;
            timer         <= 16'h0000;
            shifter       <= 24'h000000;
            bit_cnt       <= 5'h00;
            sck_cnt       <= 8'h00;
            line_cnt      <= 2'h0;
            clear_n       <= 1'b0;
            comm_enable_n <= 1'b1;
            serial_clk    <= 1'b1;
            serial_data   <= 1'b1;
        end
        else
        begin
            unique case (state)
                soc_pkg::SOC_ST_CLEAR:
                begin
                    clear_n       <= 1'b0;
                    comm_enable_n <= 1'b1;
                    timer         <= timer + 16'h0001;
                    if (timer == 16'(CLR_CYC - 1))
                    begin
                        clear_n <= 1'b1;
                        timer   <= 16'h0000;
                        state   <= soc_pkg::SOC_ST_WAIT;
                    end
                end
                soc_pkg::SOC_ST_WAIT:
                begin
                    timer <= timer + 16'h0001;
                    if (timer == 16'(XCE_CYC - 1))
                    begin
                        ready <= 1'b1;
                        state <= soc_pkg::SOC_ST_IDLE;
                    end
                end
                soc_pkg::SOC_ST_IDLE:
                begin
                    step <= 4'h0;
                    if (cmd_ok)
                    begin
                        unique case (cmd)
                            4'h1: seq <= soc_pkg::SOC_SEQ_CONFIG;
                            4'h2: seq <= soc_pkg::SOC_SEQ_SRESET;
                            4'h4: seq <= soc_pkg::SOC_SEQ_RAW;
                            default: seq <= soc_pkg::SOC_SEQ_HOLD;
                        endcase
                        last_step <= (cmd == 4'h1) ? `SOC_CONFIG_STEPS : 4'h0;
                        state     <= soc_pkg::SOC_ST_LOAD;
                    end
                end
                soc_pkg::SOC_ST_LOAD:
                begin
                    shifter       <= {step_data, step_addr, `SOC_CHIP_ID};
                    bit_cnt       <= 5'h00;
                    sck_cnt       <= 8'h00;
                    comm_enable_n <= 1'b0;
                    state         <= soc_pkg::SOC_ST_SHIFT;
                end
                soc_pkg::SOC_ST_SHIFT:
                begin
                    sck_cnt <= sck_cnt + 8'h01;
                    if (sck_cnt == 8'h00)
                    begin
                        serial_clk  <= 1'b0;
                        serial_data <= shifter[0];
                    end
                    else if (sck_cnt == 8'(SCK_HALF))
                    begin
                        serial_clk <= 1'b1;
                    end
                    else if (sck_cnt == 8'(2 * SCK_HALF - 1))
                    begin
                        sck_cnt <= 8'h00;
                        shifter <= {1'b1, shifter[23:1]};
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt == 5'd23)
                        begin
                            state <= soc_pkg::SOC_ST_GAP;
                        end
                    end
                end
                soc_pkg::SOC_ST_GAP:
                begin
                    comm_enable_n <= 1'b1;
                    serial_data   <= 1'b1;
                    sck_cnt       <= sck_cnt + 8'h01;
                    timer         <= 16'h0000;
                    line_cnt      <= 2'h0;
                    if (sck_cnt == 8'(2 * SCK_HALF - 1))
                    begin
                        if (seq == soc_pkg::SOC_SEQ_HOLD)
                        begin
                            state <= soc_pkg::SOC_ST_HWAIT;
                        end
                        else if (step != last_step)
                        begin
                            step  <= step + 4'h1;
                            state <= soc_pkg::SOC_ST_LOAD;
                        end
                        else
                        begin
                            state <= soc_pkg::SOC_ST_IDLE;
                        end
                    end
                end
                soc_pkg::SOC_ST_HWAIT:
                begin
                    timer <= timer + 16'h0001;
                    if (!slave_mode && hs_prev && !hs_sync[1])
                    begin
                        line_cnt <= line_cnt + 2'h1;
                    end
                    if ((!slave_mode && line_cnt == 2'(`SOC_HOLD_LINES))
                        || (slave_mode && timer == 16'(`SOC_HOLD_LINES * LINE_CYC)))
                    begin
                        state <= soc_pkg::SOC_ST_IDLE;
                    end
                end
                default: state <= soc_pkg::SOC_ST_IDLE;
            endcase
        end
    end

    // ======================================================
    // Sync pins: driven High in slave mode, released in master mode
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            vertical_sync_out    <= 1'b1;
            horizontal_sync_out  <= 1'b1;
            vertical_sync_oe_n   <= 1'b1;
            horizontal_sync_oe_n <= 1'b1;
        end
        else
        begin
            vertical_sync_out    <= 1'b1;
            horizontal_sync_out  <= 1'b1;
            vertical_sync_oe_n   <= !slave_mode;
            horizontal_sync_oe_n <= !slave_mode;
        end
    end

endmodule

// file: hdl/soc_cfg.svh
`ifndef SOC_CFG_SVH
`define SOC_CFG_SVH

// ==========================================================
// Timing
`define SOC_CLK_NS          100
`define SOC_CLR_LOW_NS      500
`define SOC_CLR_CYC         ((`SOC_CLR_LOW_NS + `SOC_CLK_NS - 1) / `SOC_CLK_NS)
`define SOC_XCE_WAIT_NS     20000
`define SOC_XCE_CYC         ((`SOC_XCE_WAIT_NS + `SOC_CLK_NS - 1) / `SOC_CLK_NS)
`define SOC_HOLD_LINES      2
`define SOC_LINE_CYC        148
`define SOC_SCK_HALF        2

// ==========================================================
// Own register offsets (AXI4-Lite byte addresses)
`define SOC_OFS_CTRL        8'h00
`define SOC_OFS_CONFIG      8'h04
`define SOC_OFS_RAW         8'h08
`define SOC_OFS_STATUS      8'h0C

// Control bits
`define SOC_CTRL_CONFIG     0
`define SOC_CTRL_SRESET     1
`define SOC_CTRL_RAW        2
`define SOC_CTRL_HOLD       3
`define SOC_CTRL_SLAVE      8
`define SOC_CTRL_HOLDVAL    9

// Config fields
`define SOC_CFG_CLK74       0
`define SOC_CFG_OUT12       1
`define SOC_CFG_ADC12       2
`define SOC_CFG_FR_LO       4
`define SOC_CFG_FMT_LO      8
`define SOC_CONFIG_RESET    32'h0000_0D16

// Status bits
`define SOC_STAT_BUSY       0
`define SOC_STAT_READY      1
`define SOC_STAT_REFUSED    2

// ==========================================================
// Device register map
`define SOC_CHIP_ID         8'h02
`define SOC_DEV_HOLD        8'h01
`define SOC_DEV_SRESET      8'h03
`define SOC_DEV_ADC         8'h05
`define SOC_DEV_FRAME_RATE  8'h09
`define SOC_DEV_OUTPUT      8'h44
`define SOC_DEV_CLK1        8'h5C
`define SOC_DEV_CLK2        8'h5D
`define SOC_DEV_CLK3        8'h5E
`define SOC_DEV_CLK4        8'h5F
`define SOC_DEV_STANDBY     8'h00

// Device values
`define SOC_CLK1_10BIT      8'h28
`define SOC_CLK1_12BIT      8'h18
`define SOC_CLK24_37M       8'h00
`define SOC_CLK24_74M       8'h10
`define SOC_CLK3_VAL        8'h20
`define SOC_FMT_CSI2        4'h0
`define SOC_FMT_LVDS2       4'hD
`define SOC_FMT_LVDS4       4'hE
`define SOC_FMT_LVDS8       4'hF
`define SOC_FR_PROHIBITED   2'h3
`define SOC_CONFIG_STEPS    4'h8

`endif

// file: hdl/soc_pkg.sv
package soc_pkg;
    typedef enum logic [2:0] {
        SOC_ST_CLEAR = 3'h0,
        SOC_ST_WAIT  = 3'h1,
        SOC_ST_IDLE  = 3'h3,
        SOC_ST_LOAD  = 3'h2,
        SOC_ST_SHIFT = 3'h6,
        SOC_ST_GAP   = 3'h7,
        SOC_ST_HWAIT = 3'h5
    } soc_state_t;

    typedef enum logic [1:0] {
        SOC_SEQ_CONFIG = 2'h0,
        SOC_SEQ_SRESET = 2'h1,
        SOC_SEQ_RAW    = 2'h2,
        SOC_SEQ_HOLD   = 2'h3
    } soc_seq_t;
endpackage

// file: dv/soc_sva.sv
`timescale 1ns/1ps
// ====
// Port checker
module soc_sva #(
    parameter int XCE_CYC = 200
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        clear_n,
    input wire logic        comm_enable_n,
    input wire logic        serial_clk,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        vertical_sync_oe_n,
    input wire logic        vertical_sync_out,
    input wire logic        horizontal_sync_oe_n,
    input wire logic        horizontal_sync_out
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    int unsigned since_clr;
    int unsigned bits;
    always_ff @(posedge aclk)
        since_clr <= clear_n ? since_clr + 1 : 0;
    always_ff @(posedge aclk)
        bits <= $fell(comm_enable_n) ? 0 : bits + (serial_clk && !$past(serial_clk));
    sequence s_clear_low;
        !clear_n [*4];
    endsequence
    a_clear_cs_high: assert property (!clear_n |-> comm_enable_n)
        else $error("chip select low during clear");
    a_clear_hold_low: assert property ($rose(aresetn) |-> s_clear_low)
        else $error("clear released too early");
    a_wait_comm: assert property ($fell(comm_enable_n) |-> since_clr >= XCE_CYC)
        else $error("frame started too soon after clear");
    a_frame_bits: assert property ($rose(comm_enable_n) |-> bits == 24)
        else $error("frame not 24 bits");
    a_sck_idle: assert property (comm_enable_n && $past(comm_enable_n) |-> serial_clk)
        else $error("serial clock not idle high");
    a_sync_high: assert property (!vertical_sync_oe_n |->
        vertical_sync_out && horizontal_sync_out)
        else $error("driven sync not high");
    a_oe_pair: assert property (vertical_sync_oe_n == horizontal_sync_oe_n)
        else $error("sync enables differ");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule

bind soc_host soc_sva #(.XCE_CYC(XCE_CYC)) u_soc_sva (.*);

// file: dv/soc_sensor_model.sv
`timescale 1ns/1ps
// ====
// Sensor register model
module soc_sensor_model (
    input wire logic aclk,
    input wire logic clear_n,
    input wire logic comm_enable_n,
    input wire logic serial_clk,
    input wire logic serial_data,
    output logic     hs_dev
);
    logic [7:0]   regs [256];
    logic [7:0]   pend [256];
    logic [255:0] pv;
    logic [23:0]  sh;
    logic [2:0]   hcnt = 3'h0;
    int           n;
    always @(posedge aclk)
        hcnt <= hcnt + 3'h1;
    assign hs_dev = hcnt[2];
    always @(negedge comm_enable_n)
        n <= 0;
    always @(posedge serial_clk)
        if (!comm_enable_n)
        begin
            sh <= {serial_data, sh[23:1]};
            n <= n + 1;
        end
    task automatic init();
        foreach (regs[i]) regs[i] = 8'h00;
        regs[8'h05] = 8'h01;
        regs[8'h09] = 8'h01;
        regs[8'h5C] = 8'h18;
        regs[8'h5D] = 8'h10;
        regs[8'h5E] = 8'h20;
        regs[8'h5F] = 8'h10;
        pv = '0;
    endtask
    always @(posedge comm_enable_n or negedge clear_n)
        if (!clear_n)
            init();
        else if (n == 24 && sh[7:0] == 8'h02)
        begin
            if (sh[15:8] == 8'h03 && sh[16])
                init();
            else if (sh[15:8] == 8'h01)
            begin
                regs[8'h01] = sh[23:16];
                if (!sh[16])
                    foreach (pv[i]) if (pv[i]) regs[i] = pend[i];
                if (!sh[16])
                    pv = '0;
            end
            else if (regs[8'h01][0])
            begin
                pend[sh[15:8]] = sh[23:16];
                pv[sh[15:8]] = 1'b1;
            end
            else
                regs[sh[15:8]] = sh[23:16];
        end
endmodule

// file: dv/soc_host_test.sv
`timescale 1ns/1ps
`define DEV(a) u_soc_sensor_model.regs[a]
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module soc_host_test;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, clear_n, comm_enable_n, serial_clk, serial_data;
    logic        vertical_sync_out, vertical_sync_oe_n, horizontal_sync_out, horizontal_sync_oe_n;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    wire         hs_dev;
    wire         vertical_sync_in = vertical_sync_oe_n ? 1'b1 : vertical_sync_out;
    wire         horizontal_sync_in = horizontal_sync_oe_n ? hs_dev : horizontal_sync_out;
    int          bad_count, n_compared;
    logic [3:0]  fmts [4] = '{4'hD, 4'hE, 4'hF, 4'h0};
    soc_host #(.XCE_CYC(10), .LINE_CYC(4)) u_soc_host (.*);
    soc_sensor_model u_soc_sensor_model (.*);
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        tb = 1'b0;
        while (!tb)
        begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        logic ta, tr;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        tr = 1'b0;
        while (!tr)
        begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask
    task automatic wait_idle();
        do
        begin
            rd_reg(8'h0C);
        end while (rd[0] !== 1'b0 || rd[1] !== 1'b1);
    endtask
    task automatic print_verdict();
        $display("Compared %0d, mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    initial
    begin
        repeat (40000) @(posedge aclk);
        bad_count++;
        print_verdict();
    end
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd_reg(8'h04);
        `CHK(rd, 32'h0000_0D16)
        wr(8'h00, 32'h1);
        rd_reg(8'h0C);
        `CHK(rd[2], 1'b1)
        wr(8'h0C, 32'h4);
        wait_idle();
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h04, {20'h0, fmts[i], 2'h0, 2'(i % 3), 1'b0, !i[0], i[1], i[0]});
            wr(8'h00, 32'h1);
            wait_idle();
            `CHK(`DEV(8'h44), {fmts[i], 3'h0, i[1]})
            `CHK(`DEV(8'h5C), i[1] ? 8'h18 : 8'h28)
            `CHK(`DEV(8'h5D), i[0] ? 8'h10 : 8'h00)
            `CHK(`DEV(8'h5E), 8'h20)
            `CHK(`DEV(8'h5F), i[0] ? 8'h10 : 8'h00)
            `CHK(`DEV(8'h09), 8'(i % 3))
            `CHK(`DEV(8'h05), 8'(!i[0]))
            `CHK(`DEV(8'h00), 8'h00)
        end
        wr(8'h00, 32'h2);
        rd_reg(8'h0C);
        `CHK(rd[2], 1'b1)
        wr(8'h0C, 32'h4);
        wr(8'h04, 32'h0F30);
        wr(8'h00, 32'h1);
        rd_reg(8'h0C);
        `CHK(rd[2], 1'b1)
        `CHK(`DEV(8'h44), 8'h01)
        wr(8'h0C, 32'h4);
        wr(8'h04, 32'h0F00);
        wr(8'h00, 32'h1);
        wait_idle();
        wr(8'h00, 32'h2);
        wait_idle();
        `CHK(`DEV(8'h44), 8'h00)
        `CHK(`DEV(8'h09), 8'h01)
        wr(8'h00, 32'h0308);
        wait_idle();
        wr(8'h08, 32'h0005);
        wr(8'h00, 32'h4);
        wait_idle();
        `CHK(`DEV(8'h05), 8'h01)
        wr(8'h00, 32'h0108);
        wait_idle();
        `CHK(`DEV(8'h05), 8'h00)
        wr(8'h00, 32'h0208);
        wait_idle();
        `CHK(`DEV(8'h01), 8'h01)
        rd_reg(8'h10);
        `CHK(rsp, 2'h2)
        wr(8'h20, 32'h1);
        `CHK(rsp, 2'h2)
        print_verdict();
    end
endmodule
